// File: verilog/sbsp_pkg.sv
// constants for the burst memory pin-control block
// assumes one 50 MHz clock and synchronous sampling of all pins except output enable
package sbsp_pkg;
    localparam int unsigned ADDR_W_DEF     = 10;
    localparam int unsigned LANES_DEF      = 4;
    localparam int unsigned LANE_W         = 9;
    localparam int unsigned BURST_BITS     = 2;
    localparam int unsigned READ_LATENCY   = 2;
    localparam int unsigned CLK_PERIOD_NS  = 20;
    localparam logic [1:0]  BEAT_STEP      = 2'h1;
endpackage

// File: verilog/sbsp_if.sv
// memory port carrier between the controller and its storage
// assumes the storage captures writes and reads on sys_clk_i
`timescale 1ns/1ps
`default_nettype none
interface sbsp_mem_if #(
    parameter int unsigned ADDR_W = 10,
    parameter int unsigned LANES  = 4,
    parameter int unsigned LANE_W = 9
);
    logic                     rd_en;
    logic                     wr_en;
    logic [ADDR_W-1:0]        addr;
    logic [LANES-1:0]         lane_we;
    logic [LANES*LANE_W-1:0]  wdata;
    logic [LANES*LANE_W-1:0]  rdata;
    modport ctrl (output rd_en, output wr_en, output addr, output lane_we, output wdata, input rdata);
    modport mem  (input rd_en, input wr_en, input addr, input lane_we, input wdata, output rdata);
endinterface
`default_nettype wire

// File: verilog/sbsp_mem.sv
// storage array with per-lane write enables and registered read data
// assumes accesses are already qualified by the clock-qualify pin
`timescale 1ns/1ps
`default_nettype none
module sbsp_mem #(
    parameter int unsigned ADDR_W = 10,
    parameter int unsigned LANES  = 4,
    parameter int unsigned LANE_W = 9
) (
    // clock
    input  wire logic sys_clk_i,
    // memory port
    sbsp_mem_if.mem   mem
);
    logic [LANES*LANE_W-1:0] store [0:(1<<ADDR_W)-1];
    logic [LANES*LANE_W-1:0] rdata_q;

    always_ff @(posedge sys_clk_i) begin
        if (mem.wr_en) begin
            for (int i = 0; i < int'(LANES); i++) begin
                if (mem.lane_we[i]) begin
                    store[mem.addr][i*LANE_W +: LANE_W] <= mem.wdata[i*LANE_W +: LANE_W];
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (mem.rd_en) begin
            rdata_q <= store[mem.addr];
        end
    end

    assign mem.rdata = rdata_q;
endmodule
`default_nettype wire

// File: verilog/sbsp_top.sv
// pin-control logic of a synchronous pipelined burst static memory
// assumes all pins synchronous to sys_clk_i; output enable pin gates the drive directly, unsampled
//
// Contract
// RULE1 - address pins captured on each recognized load edge select the location
// RULE2 - each low lane select with write strobe writes only its own byte and parity
// RULE3 - write strobe sampled only while clock-qualify is low
// RULE4 - controller drives write strobe low to start a write, else a read
// RULE5 - advance high with clock-qualify low steps the burst counter
// RULE6 - advance low loads a fresh address and starts a new access
// RULE7 - controller loads a new address after a deselect, not an advance
// RULE8 - edges with clock-qualify high are ignored by all synchronous logic
// RULE9 - selected only when first and third selects low and second high
// RULE10 - output enable low lets data pins drive, subject to internal direction
// RULE11 - output enable high keeps data pins released as inputs
// RULE12 - pins released during write data, first cycle out of deselect, and deselect
// RULE13 - strap high selects interleaved burst order, low selects linear
// RULE14 - clock-qualify high freezes state and never deselects
// RULE15 - burst counter wraps within the two lowest address bits
// RULE16 - read data and write data both two recognized edges after the address
`timescale 1ns/1ps
`default_nettype none
module sbsp_top #(
    parameter int unsigned ADDR_W = sbsp_pkg::ADDR_W_DEF,
    parameter int unsigned LANES  = sbsp_pkg::LANES_DEF
) (
    // clock and reset
    input  wire logic                                 sys_clk_i,
    input  wire logic                                 nrst_i,
    // address and control pins
    input  wire logic [ADDR_W-1:0]                    addr_i,
    input  wire logic [LANES-1:0]                     lane_write_select_n_i,
    input  wire logic                                 write_strobe_n_i,
    input  wire logic                                 advance_or_load_sel_i,
    input  wire logic                                 clock_qualify_n_i,
    input  wire logic                                 chip_select_first_n_i,
    input  wire logic                                 chip_select_second_i,
    input  wire logic                                 chip_select_third_n_i,
    input  wire logic                                 output_enable_n_i,
    input  wire logic                                 burst_order_sel_i,
    // data and parity lanes
    input  wire logic [LANES*sbsp_pkg::LANE_W-1:0]    data_lane_bits_i,
    output logic      [LANES*sbsp_pkg::LANE_W-1:0]    data_lane_bits_o,
    output logic                                      data_lane_bits_oe_n_o
);
    localparam int unsigned LW = sbsp_pkg::LANE_W;
    localparam int unsigned BB = sbsp_pkg::BURST_BITS;

    if (ADDR_W <= BB || ADDR_W > 24 || LANES < 1 || LANES > 8) begin : g_bad_params
        $error("sbsp_top: unsupported ADDR_W or LANES");
    end

    // ************************************************************
    // pipeline stage types
    // ************************************************************
    typedef enum logic [2:0] {
        SBSP_IDLE  = 3'b001,
        SBSP_READ  = 3'b010,
        SBSP_WRITE = 3'b100
    } sbsp_op_e;

    // ************************************************************
    // cycle qualification and decode
    // ************************************************************
    logic     take;
    logic     selected;
    logic     loading;
    sbsp_op_e new_op;

    assign take     = ~clock_qualify_n_i;                                    // [RULE8] [RULE14]
    assign selected = ~chip_select_first_n_i & chip_select_second_i
                      & ~chip_select_third_n_i;                              // [RULE9]
    assign loading  = ~advance_or_load_sel_i;                                // [RULE6]

    // burst step: interleaved xors the beat count, linear adds it
    function automatic logic [1:0] sbsp_beat(input logic [1:0] start, input logic [1:0] cnt,
                                             input logic interleave);
        sbsp_beat = interleave ? (start ^ cnt) : 2'(start + cnt);            // [RULE13] [RULE15]
    endfunction

    // ************************************************************
    // address stage
    // ************************************************************
    sbsp_op_e          burst_op_q;
    logic [ADDR_W-1:0] base_addr_q;
    logic [1:0]        beat_cnt_q;
    logic              interleave_q;
    sbsp_op_e          op_a_q;
    logic [ADDR_W-1:0] addr_a_q;
    logic [LANES-1:0]  lanes_a_q;
    logic              desel_a_q;

    always_comb begin
        new_op = SBSP_IDLE;
        if (loading) begin
            if (selected) begin
                new_op = write_strobe_n_i ? SBSP_READ : SBSP_WRITE;          // [RULE3] [RULE4]
            end
        end else begin
            new_op = burst_op_q;                                              // [RULE7]
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            interleave_q <= 1'b1;
        end else if (take) begin
            interleave_q <= burst_order_sel_i;                               // [RULE13]
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            burst_op_q  <= SBSP_IDLE;
            base_addr_q <= '0;
            beat_cnt_q  <= 2'h0;
        end else if (take) begin
            if (loading) begin
                burst_op_q  <= new_op;
                base_addr_q <= addr_i;                                       // [RULE1] [RULE6]
                beat_cnt_q  <= 2'h0;
            end else begin
                beat_cnt_q  <= 2'(beat_cnt_q + sbsp_pkg::BEAT_STEP);         // [RULE5]
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            op_a_q    <= SBSP_IDLE;
            addr_a_q  <= '0;
            lanes_a_q <= '0;
            desel_a_q <= 1'b1;
        end else if (take) begin
            op_a_q    <= new_op;
            lanes_a_q <= ~lane_write_select_n_i;                             // [RULE2]
            desel_a_q <= (new_op == SBSP_IDLE);
            if (loading) begin
                addr_a_q <= addr_i;                                          // [RULE1]
            end else begin
                addr_a_q <= {base_addr_q[ADDR_W-1:BB],
                             sbsp_beat(base_addr_q[1:0], 2'(beat_cnt_q + sbsp_pkg::BEAT_STEP),
                                       interleave_q)};                       // [RULE5] [RULE15]
            end
        end
    end

    // ************************************************************
    // data stage: second recognized edge
    // ************************************************************
    sbsp_op_e          op_b_q;
    logic [ADDR_W-1:0] addr_b_q;
    logic [LANES-1:0]  lanes_b_q;
    logic              first_after_desel_q;

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            op_b_q              <= SBSP_IDLE;
            addr_b_q            <= '0;
            lanes_b_q           <= '0;
            first_after_desel_q <= 1'b1;
        end else if (take) begin
            op_b_q              <= op_a_q;                                   // [RULE16]
            addr_b_q            <= addr_a_q;
            lanes_b_q           <= lanes_a_q;
            first_after_desel_q <= desel_a_q;
        end
    end

    // ************************************************************
    // storage
    // ************************************************************
    sbsp_mem_if #(.ADDR_W(ADDR_W), .LANES(LANES), .LANE_W(LW)) mem_bus ();

    // reads launch from the data stage so data leaves on the third recognized edge, two after the address
    assign mem_bus.rd_en   = take & (op_b_q == SBSP_READ);                   // [RULE16]
    assign mem_bus.wr_en   = take & (op_b_q == SBSP_WRITE);                  // [RULE16]
    assign mem_bus.addr    = addr_b_q;
    assign mem_bus.lane_we = lanes_b_q;                                      // [RULE2]
    assign mem_bus.wdata   = data_lane_bits_i;

    sbsp_mem #(.ADDR_W(ADDR_W), .LANES(LANES), .LANE_W(LW)) u_mem (
        .sys_clk_i (sys_clk_i),
        .mem       (mem_bus)
    );

    // ************************************************************
    // output drive
    // ************************************************************
    logic drive_q;

    // one operation per data stage, so read and write never share the port
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            drive_q <= 1'b0;
        end else if (take) begin
            drive_q <= (op_b_q == SBSP_READ) & ~first_after_desel_q;         // [RULE12] [RULE16]
        end
    end

    assign data_lane_bits_o      = mem_bus.rdata;
    assign data_lane_bits_oe_n_o = ~(drive_q & ~output_enable_n_i);          // [RULE10] [RULE11] [RULE12]
endmodule
`default_nettype wire

// File: dv/sbsp_monitor.sv
// assertions on the pins of the burst memory block
// assumes a bind to sbsp_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module sbsp_monitor #(
    parameter int unsigned LANES = 4
) (
    // clock and reset
    input wire logic                              sys_clk_i,
    input wire logic                              nrst_i,
    // control pins
    input wire logic                              write_strobe_n_i,
    input wire logic                              advance_or_load_sel_i,
    input wire logic                              clock_qualify_n_i,
    input wire logic                              chip_select_first_n_i,
    input wire logic                              chip_select_second_i,
    input wire logic                              chip_select_third_n_i,
    input wire logic                              output_enable_n_i,
    // data pins
    input wire logic [LANES*sbsp_pkg::LANE_W-1:0] data_lane_bits_o,
    input wire logic                              data_lane_bits_oe_n_o
);
    logic qual;
    logic sel;
    logic ld;
    assign qual = !clock_qualify_n_i;
    assign sel  = !chip_select_first_n_i && chip_select_second_i && !chip_select_third_n_i;
    assign ld   = qual && sel && !advance_or_load_sel_i;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    // ****
    // pin checks
    // ****
    a_oe_pin_release: assert property (output_enable_n_i |-> data_lane_bits_oe_n_o)
        else $error("pins driven while output enable high");
    a_read_drives: assert property ((ld && write_strobe_n_i) ##1 qual ##1 qual ##1 !output_enable_n_i
        |-> !data_lane_bits_oe_n_o) else $error("read data stage not driven");
    a_burst_drives: assert property ((ld && write_strobe_n_i) ##1 (qual && advance_or_load_sel_i) ##1 qual ##1 qual
        ##1 !output_enable_n_i |-> !data_lane_bits_oe_n_o) else $error("burst beat not driven");
    a_write_release: assert property ((ld && !write_strobe_n_i) ##1 qual ##1 qual |=> data_lane_bits_oe_n_o)
        else $error("pins driven in write data stage");
    a_deselect_release: assert property ((qual && !sel && !advance_or_load_sel_i) ##1 qual ##1 qual
        |=> data_lane_bits_oe_n_o) else $error("pins driven after deselect");
    a_stall_oe_hold: assert property (clock_qualify_n_i |=> $stable(data_lane_bits_oe_n_o)
        || $changed(output_enable_n_i)) else $error("drive changed on masked edge");
    a_stall_data_hold: assert property (clock_qualify_n_i && !data_lane_bits_oe_n_o
        |=> $stable(data_lane_bits_o)) else $error("read data changed on masked edge");
    a_reset_idle: assert property ($rose(nrst_i) |-> data_lane_bits_oe_n_o)
        else $error("pins driven right after reset");
endmodule
`default_nettype wire

// File: dv/sbsp_host.sv
// model of the memory controller on the command and write data pins
// assumes the bench calls one task per clock slot
`timescale 1ns/1ps
`default_nettype none
module sbsp_host (
    // clock
    input  wire logic   sys_clk_i,
    // command pins
    output logic [9:0]  addr_o,
    output logic [3:0]  lanes_n_o,
    output logic        write_n_o,
    output logic        advance_o,
    output logic        qualify_n_o,
    output logic [2:0]  cs_o,
    // write data pins
    output logic [35:0] data_o
);
    logic [107:0] pend_d;
    logic [2:0]   pend_wr;
    initial begin
        {addr_o, lanes_n_o, write_n_o, advance_o, qualify_n_o, cs_o} = {10'h000, 4'hF, 3'h4, 3'h0};
        data_o = 36'h0;
        pend_wr = 3'h0;
        pend_d = 108'h0;
    end
    // ****
    // command slots
    // ****
    task automatic beat(input logic [9:0] a, input logic wr, input logic adv, input logic [2:0] cs,
                        input logic [3:0] ln, input logic [35:0] wd);
        @(posedge sys_clk_i);
        #1;
        {addr_o, lanes_n_o, advance_o, qualify_n_o, cs_o} = {a, ln, adv, 1'b0, cs};
        write_n_o = !wr;
        pend_wr = {pend_wr[1:0], wr};
        pend_d = {pend_d[71:0], wd};
        data_o = pend_wr[2] ? pend_d[107:72] : ~data_o;
    endtask
    // masked slot carrying a write that must be ignored
    task automatic stall(input logic [9:0] a);
        @(posedge sys_clk_i);
        #1;
        {addr_o, lanes_n_o, write_n_o, advance_o, qualify_n_o, cs_o} = {a, 4'h0, 3'h1, 3'h2};
        data_o = ~data_o;
    endtask
endmodule
`default_nettype wire

// File: dv/sbsp_tb.sv
// self-checking bench for the burst memory pin-control block
// assumes sbsp_host drives the command and write data pins
`timescale 1ns/1ps
`default_nettype none
module sbsp_tb;
    logic        sys_clk_i = 1'b0;
    logic        nrst_i    = 1'b0;
    logic        oe_n      = 1'b0;
    logic        strap     = 1'b1;
    logic [9:0]  addr;
    logic [3:0]  lanes_n;
    logic        write_n;
    logic        advance;
    logic        qualify_n;
    logic [2:0]  cs;
    logic [35:0] wdata;
    logic [35:0] rdata;
    logic        drv_n;
    int          failures  = 0;
    int          checks    = 0;
    int          cycles    = 0;
    always #10 sys_clk_i = ~sys_clk_i;
    sbsp_host i_sbsp_host (.sys_clk_i(sys_clk_i), .addr_o(addr), .lanes_n_o(lanes_n), .write_n_o(write_n),
        .advance_o(advance), .qualify_n_o(qualify_n), .cs_o(cs), .data_o(wdata));
    sbsp_top i_sbsp_top (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .addr_i(addr), .lane_write_select_n_i(lanes_n),
        .write_strobe_n_i(write_n), .advance_or_load_sel_i(advance), .clock_qualify_n_i(qualify_n),
        .chip_select_first_n_i(cs[2]), .chip_select_second_i(cs[1]), .chip_select_third_n_i(cs[0]),
        .output_enable_n_i(oe_n), .burst_order_sel_i(strap), .data_lane_bits_i(wdata),
        .data_lane_bits_o(rdata), .data_lane_bits_oe_n_o(drv_n));
    // ****
    // helpers
    // ****
    function automatic logic [35:0] dval(input logic [1:0] n);
        return {n, 7'h55, n, 25'h0ABCDEF};
    endfunction
    function automatic logic [9:0] nth(input logic [9:0] a, input int n, input logic lin);
        return {a[9:2], lin ? 2'(a[1:0] + n) : 2'(a[1:0] ^ n)};
    endfunction
    task automatic chk_data(input string what, input logic [35:0] exp);
        checks++;
        if (rdata !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, rdata);
        end
    endtask
    task automatic chk_flag(input string what, input logic exp);
        checks++;
        if (drv_n !== exp) begin
            failures++;
            $display("BAD %s expected %b seen %b", what, exp, drv_n);
        end
    endtask
    task automatic op(input logic [9:0] a, input logic wr, input logic [2:0] c, input logic [3:0] ln,
                      input logic [35:0] wd);
        i_sbsp_host.beat(a, wr, 1'b0, c, ln, wd);
        repeat (3) i_sbsp_host.beat(10'h000, 1'b0, 1'b0, 3'h0, 4'hF, 36'h0);
    endtask
    task automatic read4(input logic [9:0] a, input logic adv, input logic lin);
        logic [9:0] x;
        for (int i = 0; i < 7; i++) begin
            if (i < 4)
                i_sbsp_host.beat(nth(a, i, lin), 1'b0, adv && i > 0, 3'h2, 4'hF, 36'h0);
            else
                i_sbsp_host.beat(10'h000, 1'b0, 1'b0, 3'h0, 4'hF, 36'h0);
            if (i >= 3) begin
                x = nth(a, i - 3, lin);
                chk_data("read beat", dval(x[1:0] ^ 2'h1));
                chk_flag("read drive", 1'b0);
            end
        end
    endtask
    // ****
    // scenarios
    // ****
    task automatic s_burst();
        for (int i = 0; i < 4; i++)
            i_sbsp_host.beat(10'h005, 1'b1, i > 0, 3'h2, 4'h0, dval(2'(i)));
        repeat (2) i_sbsp_host.beat(10'h000, 1'b0, 1'b0, 3'h0, 4'hF, 36'h0);
        read4(10'h005, 1'b0, 1'b0);
        read4(10'h006, 1'b1, 1'b0);
        strap = 1'b0;
        read4(10'h005, 1'b1, 1'b1);
    endtask
    task automatic s_lanes();
        op(10'h004, 1'b1, 3'h2, 4'hA, 36'hF_FFFF_FFFF);
        chk_flag("write release", 1'b1);
        op(10'h004, 1'b0, 3'h2, 4'hF, 36'h0);
        chk_data("lane write", dval(2'h1) | 36'h0_07FC_01FF);
    endtask
    task automatic s_select();
        for (int c = 0; c < 8; c++) begin
            if (c != 2) begin
                op(10'h005, 1'b0, 3'(c), 4'hF, 36'h0);
                chk_flag("deselect", 1'b1);
            end
        end
        oe_n = 1'b1;
        op(10'h005, 1'b0, 3'h2, 4'hF, 36'h0);
        chk_flag("oe pin high", 1'b1);
        oe_n = 1'b0;
    endtask
    task automatic s_stall();
        i_sbsp_host.beat(10'h004, 1'b0, 1'b0, 3'h2, 4'hF, 36'h0);
        repeat (2) i_sbsp_host.beat(10'h000, 1'b0, 1'b0, 3'h0, 4'hF, 36'h0);
        for (int i = 0; i < 4; i++) begin
            i_sbsp_host.stall(10'h004);
            chk_data("stall hold", dval(2'h1) | 36'h0_07FC_01FF);
            chk_flag("stall drive", 1'b0);
        end
        op(10'h004, 1'b0, 3'h2, 4'hF, 36'h0);
        chk_data("masked write", dval(2'h1) | 36'h0_07FC_01FF);
    endtask
    task automatic finish_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 1000) begin
            failures++;
            finish_test();
        end
    end
    initial begin
        repeat (6) @(posedge sys_clk_i);
        #1;
        nrst_i = 1'b1;
        s_burst();
        s_lanes();
        s_select();
        s_stall();
        finish_test();
    end
endmodule
bind sbsp_top sbsp_monitor #(.LANES(LANES)) i_sbsp_monitor (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .write_strobe_n_i(write_strobe_n_i), .advance_or_load_sel_i(advance_or_load_sel_i),
    .clock_qualify_n_i(clock_qualify_n_i), .chip_select_first_n_i(chip_select_first_n_i),
    .chip_select_second_i(chip_select_second_i), .chip_select_third_n_i(chip_select_third_n_i),
    .output_enable_n_i(output_enable_n_i), .data_lane_bits_o(data_lane_bits_o),
    .data_lane_bits_oe_n_o(data_lane_bits_oe_n_o));
`default_nettype wire
